//--- hw/core_exception_priority.sv
`timescale 1ns/1ns
`include "exc_map.svh"
module core_exception_priority
  import exc_pkg::*;
(
  input  wire logic        clk_in,             // Core clock, 50 MHz.
  input  wire logic        rstn_in,            // Async reset, active low.
  input  wire logic        psel_in,            // APB select.
  input  wire logic        penable_in,         // APB access phase.
  input  wire logic        pwrite_in,          // APB write when high.
  input  wire logic [7:0]  paddr_in,           // APB byte address.
  input  wire logic [31:0] pwdata_in,          // APB write data.
  output logic             pready_out,         // APB ready.
  output logic      [31:0] prdata_out,         // APB read data.
  output logic             pslverr_out,        // APB error, unmapped.
  input  wire logic [31:0] irq_in,             // Peripheral request levels.
  input  wire logic        nmi_n_in,           // Nonmaskable pin, low.
  input  wire logic        fault_in,           // Hard fault pulse.
  input  wire logic        svc_in,             // Supervisor call pulse.
  input  wire logic        exc_ack_in,         // Core takes the vector.
  input  wire logic        exc_done_in,        // Handler return pulse.
  output logic             exc_req_out,        // Vector offered.
  output vec_t             exc_vector_out,     // Offered vector number.
  output logic      [31:0] exc_addr_out,       // Offered table slot.
  output vec_t             stacked_vector_out, // Vector saved on entry.
  output logic             wake_out,           // Wake-up request.
  output logic             irq_out             // Status interrupt, high.
);
  prio_t       prio_reg [32];
  prio_t       prio_next [32];
  logic [31:0] en_reg, en_next, mask_reg, mask_next;
  logic [2:0]  status_reg, status_next, ctrl_reg, ctrl_next;
  logic [23:0] reload_reg, reload_next, tick_cur;
  logic        route_reg, route_next, pendsv_reg, pendsv_next;
  logic        tick_pend_reg, tick_pend_next, fault_reg, fault_next;
  logic        svc_reg, svc_next, nmi_pend_reg, nmi_pend_next;
  prio_t       svc_pri_reg, svc_pri_next, psv_pri_reg, psv_pri_next;
  prio_t       tck_pri_reg, tck_pri_next;
  power_mode_t mode_reg, mode_next;
  logic        pready_reg, pready_next, err_reg, err_next;
  logic [31:0] rd_reg, rd_next;
  logic        nmi_s1_reg, nmi_s2_reg, nmi_prev_reg;
  exc_state_t  state_reg, state_next;
  logic        req_reg, req_next, wake_reg, wake_next;
  vec_t        vec_reg, vec_next, stk_reg, stk_next;
  logic [31:0] addr_reg, addr_next;
  logic        irq_reg, irq_next;
  logic        wr_commit, rd_load, tick_clear, tick_wrap, nmi_edge;
  logic        taken, cand_valid, mapped;
  prio_t       cand_lvl;
  vec_t        cand_vec;
  logic [31:0] rd_word, pend_lines;

  // Reserved table slots never carry a source.
  function automatic logic is_reserved(vec_t v);
    return (v >= 6'h04 && v <= 6'h0A) || v == 6'h0C || v == 6'h0D;
  endfunction : is_reserved

  // A candidate wins only on a strictly better level, so ties keep
  // the lower vector already chosen.
  function automatic logic beats(logic have, prio_t cur, prio_t lvl);
    return !have || lvl < cur;
  endfunction : beats

  // Table slot of a vector is four bytes per entry from address zero.
  function automatic logic [31:0] slot_addr(vec_t v);
    return {24'h000000, v, 2'h0};
  endfunction : slot_addr

  tick_timer u_tick (
    .clk_in    (clk_in),
    .rstn_in   (rstn_in),
    .en_in     (ctrl_reg[`TICK_EN_BIT]),
    .sel_in    (ctrl_reg[`TICK_SEL_BIT]),
    .clear_in  (tick_clear),
    .reload_in (reload_reg),
    .cur_out   (tick_cur),
    .wrap_out  (tick_wrap)
  );

  // The pin is asynchronous, so two flops precede the edge detector.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      nmi_s1_reg   <= 1'b1;
      nmi_s2_reg   <= 1'b1;
      nmi_prev_reg <= 1'b1;
    end else begin
      nmi_s1_reg   <= nmi_n_in;
      nmi_s2_reg   <= nmi_s1_reg;
      nmi_prev_reg <= nmi_s2_reg;
    end
  end

  // A falling pin only counts once software routed it.
  assign nmi_edge   = route_reg && nmi_prev_reg && !nmi_s2_reg;
  assign pend_lines = irq_in & en_reg;
  assign taken      = state_reg == ST_OFFER && exc_ack_in;

  // Nmi beats hard fault beats the rest; the rest go by level, lowest vector on a tie.
  always_comb begin
    cand_valid = 1'b0;
    cand_lvl   = 2'h3;
    cand_vec   = 6'h00;
    if (svc_reg) begin
      cand_valid = 1'b1;
      cand_lvl   = svc_pri_reg;
      cand_vec   = `VEC_SVC;
    end
    if (pendsv_reg && beats(cand_valid, cand_lvl, psv_pri_reg)) begin
      cand_valid = 1'b1;
      cand_lvl   = psv_pri_reg;
      cand_vec   = `VEC_PENDSV;
    end
    if (tick_pend_reg && beats(cand_valid, cand_lvl, tck_pri_reg)) begin
      cand_valid = 1'b1;
      cand_lvl   = tck_pri_reg;
      cand_vec   = `VEC_TICK;
    end
    for (int i = 0; i < 32; i++) begin
      if (pend_lines[i] && beats(cand_valid, cand_lvl, prio_reg[i])) begin
        cand_valid = 1'b1;
        cand_lvl   = prio_reg[i];
        cand_vec   = `VEC_IRQ_BASE + 6'(i);
      end
    end
    if (fault_reg) begin
      cand_valid = 1'b1;
      cand_vec   = `VEC_HARD_FAULT;
    end
    if (nmi_pend_reg) begin
      cand_valid = 1'b1;
      cand_vec   = `VEC_NMI;
    end
  end

  // Offer a vector, hold it until taken, then wait for the return.
  // A newer better source waits until the handler returns.
  always_comb begin
    state_next = state_reg;
    req_next   = req_reg;
    vec_next   = vec_reg;
    addr_next  = addr_reg;
    stk_next   = stk_reg;
    case (state_reg)
      ST_IDLE: begin
        if (cand_valid) begin
          req_next   = 1'b1;
          vec_next   = cand_vec;
          addr_next  = slot_addr(cand_vec);
          state_next = ST_OFFER;
        end
      end
      ST_OFFER: begin
        if (exc_ack_in) begin
          req_next   = 1'b0;
          stk_next   = vec_reg;
          state_next = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (exc_done_in) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
        req_next   = 1'b0;
      end
    endcase
    wake_next = cand_valid && mode_reg <= PM_VERY_LOW_POWER_STOP;
    irq_next  = |(status_next & mask_next[2:0]);
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg <= ST_IDLE;
      req_reg   <= 1'b0;
      vec_reg   <= 6'h00;
      addr_reg  <= 32'h00000000;
      stk_reg   <= 6'h00;
      wake_reg  <= 1'b0;
      irq_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      req_reg   <= req_next;
      vec_reg   <= vec_next;
      addr_reg  <= addr_next;
      stk_reg   <= stk_next;
      wake_reg  <= wake_next;
      irq_reg   <= irq_next;
    end
  end

  // Read word for the current address; priority words are built per
  // register index so that unused bits always read as zero.
  always_comb begin
    rd_word = 32'h00000000;
    mapped  = 1'b1;
    if (paddr_in <= `OFF_PRIO_LAST) begin
      for (int j = 0; j < `PRIO_PER_REG; j++) begin
        rd_word[`PRIO_FIELD_STEP*j+`PRIO_FIELD_BASE +: 2] =
          prio_reg[{paddr_in[4:2], 2'(j)}];
      end
    end else begin
      case (paddr_in)
        `OFF_ENABLE:       rd_word = en_reg;
        `OFF_STATUS:       rd_word = {29'h0, status_reg};
        `OFF_MASK:         rd_word = mask_reg;
        `OFF_TICK_CTRL:    rd_word = {29'h0, ctrl_reg};
        `OFF_TICK_RELOAD:  rd_word = {8'h00, reload_reg};
        `OFF_TICK_CURRENT: rd_word = {8'h00, tick_cur};
        `OFF_TICK_CALIB:   rd_word = {8'h00, `TEN_MS_CAL};
        `OFF_NMI_ROUTE:    rd_word = {31'h0, route_reg};
        `OFF_PENDING:      rd_word = pend_lines;
        `OFF_SYS_PEND:     rd_word = {27'h0, nmi_pend_reg, fault_reg,
                                      svc_reg, tick_pend_reg, pendsv_reg};
        `OFF_ACTIVE:       rd_word = {26'h0, stk_reg};
        `OFF_POWER:        rd_word = {29'h0, mode_reg};
        `OFF_SYS_PRIO:     rd_word = {8'h00, tck_pri_reg, 6'h00,
                                      psv_pri_reg, 6'h00, svc_pri_reg,
                                      6'h00};
        default:           mapped  = 1'b0;
      endcase
    end
  end

  // Answer one cycle into the access phase; writes land on the edge
  // where the master sees ready.
  always_comb begin
    rd_load     = psel_in && penable_in && !pready_reg;
    wr_commit   = psel_in && penable_in && pready_reg && pwrite_in;
    pready_next = rd_load;
    rd_next     = (rd_load && !pwrite_in) ? rd_word : rd_reg;
    err_next    = rd_load && !mapped;
    tick_clear  = wr_commit && paddr_in == `OFF_TICK_CURRENT;
    prio_next   = prio_reg;
    en_next     = en_reg;
    mask_next   = mask_reg;
    ctrl_next   = ctrl_reg;
    reload_next = reload_reg;
    route_next  = route_reg;
    mode_next   = mode_reg;
    svc_pri_next = svc_pri_reg;
    psv_pri_next = psv_pri_reg;
    tck_pri_next = tck_pri_reg;
    status_next = status_reg;
    if (wr_commit && paddr_in <= `OFF_PRIO_LAST) begin
      for (int j = 0; j < `PRIO_PER_REG; j++) begin
        prio_next[{paddr_in[4:2], 2'(j)}] =
          pwdata_in[`PRIO_FIELD_STEP*j+`PRIO_FIELD_BASE +: 2];
      end
    end
    if (wr_commit) begin
      case (paddr_in)
        `OFF_ENABLE:      en_next     = pwdata_in;
        `OFF_STATUS:      status_next = status_reg & ~pwdata_in[2:0];
        `OFF_MASK:        mask_next   = pwdata_in;
        `OFF_TICK_CTRL:   ctrl_next   = pwdata_in[2:0];
        `OFF_TICK_RELOAD: reload_next = pwdata_in[23:0];
        `OFF_NMI_ROUTE:   route_next  = pwdata_in[0];
        `OFF_POWER: begin
          if (pwdata_in[2:0] <= 3'h5) begin
            mode_next = power_mode_t'(pwdata_in[2:0]);
          end
        end
        `OFF_SYS_PRIO: begin
          svc_pri_next = pwdata_in[`SYSPRI_SVC_LSB +: 2];
          psv_pri_next = pwdata_in[`SYSPRI_PENDSV_LSB +: 2];
          tck_pri_next = pwdata_in[`SYSPRI_TICK_LSB +: 2];
        end
        default: begin
        end
      endcase
    end
    // Events set after the clear so a coincident event is kept.
    status_next[`ST_NMI_BIT]   = status_next[`ST_NMI_BIT] | nmi_edge;
    status_next[`ST_TICK_BIT]  = status_next[`ST_TICK_BIT] | tick_wrap;
    status_next[`ST_TAKEN_BIT] = status_next[`ST_TAKEN_BIT] | taken;
    // Pending sources clear when their vector is taken; a new set wins.
    nmi_pend_next  = (nmi_pend_reg && !(taken && vec_reg == `VEC_NMI))
                     || nmi_edge;
    fault_next     = (fault_reg && !(taken && vec_reg == `VEC_HARD_FAULT))
                     || fault_in;
    svc_next       = (svc_reg && !(taken && vec_reg == `VEC_SVC)) || svc_in;
    pendsv_next    = (pendsv_reg && !(taken && vec_reg == `VEC_PENDSV)) ||
                     (wr_commit && paddr_in == `OFF_SYS_PEND &&
                      pwdata_in[`SYSPEND_SET_BIT]);
    tick_pend_next = (tick_pend_reg && !(taken && vec_reg == `VEC_TICK)) ||
                     (tick_wrap && ctrl_reg[`TICK_INT_BIT]);
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < 32; i++) prio_reg[i] <= 2'h0;
      en_reg        <= 32'h00000000;
      mask_reg      <= 32'h00000000;
      status_reg    <= 3'h0;
      ctrl_reg      <= 3'h0;
      reload_reg    <= 24'h000000;
      route_reg     <= 1'b0;
      mode_reg      <= PM_RUN;
      svc_pri_reg   <= 2'h0;
      psv_pri_reg   <= 2'h0;
      tck_pri_reg   <= 2'h0;
      nmi_pend_reg  <= 1'b0;
      fault_reg     <= 1'b0;
      svc_reg       <= 1'b0;
      pendsv_reg    <= 1'b0;
      tick_pend_reg <= 1'b0;
      pready_reg    <= 1'b0;
      rd_reg        <= 32'h00000000;
      err_reg       <= 1'b0;
    end else begin
      prio_reg      <= prio_next;
      en_reg        <= en_next;
      mask_reg      <= mask_next;
      status_reg    <= status_next;
      ctrl_reg      <= ctrl_next;
      reload_reg    <= reload_next;
      route_reg     <= route_next;
      mode_reg      <= mode_next;
      svc_pri_reg   <= svc_pri_next;
      psv_pri_reg   <= psv_pri_next;
      tck_pri_reg   <= tck_pri_next;
      nmi_pend_reg  <= nmi_pend_next;
      fault_reg     <= fault_next;
      svc_reg       <= svc_next;
      pendsv_reg    <= pendsv_next;
      tick_pend_reg <= tick_pend_next;
      pready_reg    <= pready_next;
      rd_reg        <= rd_next;
      err_reg       <= err_next;
    end
  end

  assign pready_out         = pready_reg;
  assign prdata_out         = rd_reg;
  assign pslverr_out        = err_reg;
  assign exc_req_out        = req_reg;
  assign exc_vector_out     = vec_reg;
  assign exc_addr_out       = addr_reg;
  assign stacked_vector_out = stk_reg;
  assign wake_out           = wake_reg;
  assign irq_out            = irq_reg;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  chk_prio_zero_bits: assert property (
    pready_reg && !pwrite_in && paddr_in <= `OFF_PRIO_LAST |->
    (rd_reg & ~`PRIO_FIELD_MASK) == 32'h00000000)
    else $error("priority word has bits outside the fields");
  chk_field_place: assert property (
    wr_commit && paddr_in == 8'h04 |=>
    prio_reg[5] == $past(pwdata_in[15:14]))
    else $error("priority field landed in the wrong place");
  chk_irq_map: assert property (
    $rose(req_reg) && vec_reg >= `VEC_IRQ_BASE |->
    (($past(pend_lines) >> 5'(vec_reg - `VEC_IRQ_BASE)) & 32'h1)
    == 32'h1)
    else $error("offered vector does not match a pending request");
  chk_slot_addr: assert property (
    req_reg |-> addr_reg == {24'h000000, vec_reg, 2'h0})
    else $error("table slot does not match vector");
  chk_pendsv_slot: assert property (
    req_reg && vec_reg == `VEC_PENDSV |-> addr_reg == `ADDR_PENDSV)
    else $error("pendable service slot wrong");
  chk_tick_slot: assert property (
    req_reg && vec_reg == `VEC_TICK |-> addr_reg == `ADDR_TICK)
    else $error("tick slot wrong");
  chk_stacked_vec: assert property (
    req_reg && exc_ack_in |=> stk_reg == $past(vec_reg) && !req_reg)
    else $error("stacked vector not saved on entry");
  chk_nmi_route: assert property (
    $rose(nmi_pend_reg) |-> $past(route_reg) && !$past(nmi_s2_reg))
    else $error("nonmaskable pend without routed pin");
  chk_calib_zero: assert property (
    pready_reg && !pwrite_in && paddr_in == `OFF_TICK_CALIB |->
    rd_reg[23:0] == 24'h000000)
    else $error("calibration field not zero");
  chk_wake_mode: assert property (
    wake_reg |-> $past(mode_reg) <= PM_VERY_LOW_POWER_STOP)
    else $error("wake raised in a deep mode");
  chk_no_reserved: assert property (
    req_reg |-> !is_reserved(vec_reg))
    else $error("reserved vector offered");
  cov_nmi_taken: cover property (taken && vec_reg == `VEC_NMI);
  cov_irq_taken: cover property (taken && vec_reg >= `VEC_IRQ_BASE);
  cov_irq_out: cover property ($rose(irq_reg));
endmodule : core_exception_priority

//--- hw/exc_map.svh
`ifndef EXC_MAP_SVH
`define EXC_MAP_SVH
// Behaviour
// - Four priority levels, two-bit field per source.
// - Fields at 31:30, 23:22, 15:14, 7:6; rest zero.
// - Request number is vector number minus sixteen.
// - Fixed table slots for stack, reset, nmi, faults.
// - Pendable service uses vector 14, slot 0x38.
// - Tick timer uses vector 15, slot 0x3C.
// - Taken vector number is saved when serviced.
// - Nonmaskable request from routed active-low pin.
// - Tick counts core clock or clock over 16.
// - Ten millisecond calibration field reads zero.
// - Wake-up only down to very low power stop.
// - Priority register index is request divided by four.
// - Field starts at eight times (request mod 4) plus six.

// Register byte offsets on the APB.
`define OFF_PRIO_LAST     8'h1C
`define OFF_ENABLE        8'h20
`define OFF_STATUS        8'h24
`define OFF_MASK          8'h28
`define OFF_TICK_CTRL     8'h2C
`define OFF_TICK_RELOAD   8'h30
`define OFF_TICK_CURRENT  8'h34
`define OFF_TICK_CALIB    8'h38
`define OFF_NMI_ROUTE     8'h3C
`define OFF_PENDING       8'h40
`define OFF_SYS_PEND      8'h44
`define OFF_ACTIVE        8'h48
`define OFF_POWER         8'h4C
`define OFF_SYS_PRIO      8'h50

// Priority field layout.
`define PRIO_FIELD_MASK   32'hC0C0C0C0
`define PRIO_FIELD_BASE   6
`define PRIO_FIELD_STEP   8
`define PRIO_PER_REG      4

// Vector numbers and table slots.
`define VEC_NMI           6'h02
`define VEC_HARD_FAULT    6'h03
`define VEC_SVC           6'h0B
`define VEC_PENDSV        6'h0E
`define VEC_TICK          6'h0F
`define VEC_IRQ_BASE      6'h10
`define ADDR_PENDSV       32'h00000038
`define ADDR_TICK         32'h0000003C

// Tick control bits, prescaler and calibration.
`define TICK_EN_BIT       0
`define TICK_INT_BIT      1
`define TICK_SEL_BIT      2
`define TICK_PRESCALE_MAX 4'hF
`define TEN_MS_CAL        24'h000000

// Status bits, system pend bits and system priority fields.
`define ST_NMI_BIT        0
`define ST_TICK_BIT       1
`define ST_TAKEN_BIT      2
`define SYSPEND_SET_BIT   0
`define SYSPRI_SVC_LSB    6
`define SYSPRI_PENDSV_LSB 14
`define SYSPRI_TICK_LSB   22
`endif

//--- hw/exc_pkg.sv
package exc_pkg;
  typedef logic [1:0] prio_t;
  typedef logic [5:0] vec_t;
  typedef enum logic [1:0] {ST_IDLE, ST_OFFER, ST_ACTIVE} exc_state_t;
  typedef enum logic [2:0] {
    PM_RUN, PM_WAIT, PM_STOP, PM_VERY_LOW_POWER_STOP, PM_LLS, PM_VLLS
  } power_mode_t;
endpackage : exc_pkg

//--- hw/tick_timer.sv
`timescale 1ns/1ns
`include "exc_map.svh"
module tick_timer (
  input  wire logic        clk_in,    // Core clock.
  input  wire logic        rstn_in,   // Asynchronous reset, active low.
  input  wire logic        en_in,     // Counter enable.
  input  wire logic        sel_in,    // Tick clock select.
  input  wire logic        clear_in,  // Clear current value.
  input  wire logic [23:0] reload_in, // Reload value.
  output logic      [23:0] cur_out,   // Current count.
  output logic             wrap_out   // One-cycle pulse at count end.
);
  logic [3:0]  pre_reg,  pre_next;
  logic [23:0] cur_reg,  cur_next;
  logic        wrap_reg, wrap_next;
  logic        step;

  // Select one decrement per core clock or one per sixteen.
  always_comb begin
    step      = en_in && (sel_in || pre_reg == `TICK_PRESCALE_MAX);
    pre_next  = en_in ? pre_reg + 4'h1 : 4'h0;
    cur_next  = cur_reg;
    wrap_next = 1'b0;
    if (clear_in) begin
      cur_next = 24'h000000;
    end else if (step) begin
      if (cur_reg == 24'h000000) begin
        cur_next = reload_in;
      end else begin
        cur_next  = cur_reg - 24'h000001;
        wrap_next = (cur_reg == 24'h000001);
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pre_reg  <= 4'h0;
      cur_reg  <= 24'h000000;
      wrap_reg <= 1'b0;
    end else begin
      pre_reg  <= pre_next;
      cur_reg  <= cur_next;
      wrap_reg <= wrap_next;
    end
  end

  assign cur_out  = cur_reg;
  assign wrap_out = wrap_reg;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  chk_tick_divide: assert property (
    $past(en_in) && !$past(sel_in) && !$past(clear_in) &&
    $changed(cur_reg) |-> $past(pre_reg) == `TICK_PRESCALE_MAX)
    else $error("tick stepped outside the divide by sixteen slot");
  cov_tick_wrap: cover property (wrap_reg);
endmodule : tick_timer

//--- testbench/core_exception_priority_tb.sv
`timescale 1ns/1ns
module core_exception_priority_tb;
  import exc_pkg::*;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, irq, rd, addr, a;
  logic        nmi_n, fault, svc, ack, done, req, wake, int_o;
  vec_t        vec, stk;
  logic [3:0]  delay;
  logic [37:0] va;
  int          n_fail, compares, cyc, t_s, c, g;

  core_exception_priority i_core_exception_priority (
    .clk_in(clk), .rstn_in(rst_n), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .pready_out(pready), .prdata_out(prdata), .pslverr_out(pslverr),
    .irq_in(irq), .nmi_n_in(nmi_n), .fault_in(fault), .svc_in(svc),
    .exc_ack_in(ack), .exc_done_in(done), .exc_req_out(req),
    .exc_vector_out(vec), .exc_addr_out(addr),
    .stacked_vector_out(stk), .wake_out(wake), .irq_out(int_o));
  core_model i_core_model (.clk_in(clk), .rstn_in(rst_n), .req_in(req),
    .delay_in(delay), .ack_out(ack), .done_out(done));

  // Free-running 50 MHz clock and a cycle count for rate checks.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task close_out;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out

  // An offered vector must never be a reserved table entry.
  always @(posedge clk) begin
    if (rst_n && req === 1'b1)
      chk(vec inside {[6'h04:6'h0A], 6'h0C, 6'h0D}, 1'b0);
  end

  // One APB transfer; the request holds until pready is seen at an edge.
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_fail++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    t_s = cyc;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Bounded wait for the offer line to reach a level.
  task wait_req(input logic lvl);
    int n;
    n = 0;
    while (req !== lvl && n < 60) begin
      @(posedge clk);
      n++;
    end
    if (n >= 60) begin
      n_fail++;
      close_out();
    end
  endtask : wait_req

  // Catch one offer, then let the core model take it.
  task offer;
    wait_req(1'b1);
    va = {vec, addr};
    wait_req(1'b0);
  endtask : offer

  task t_prio;
    apb(1'b1, 8'h00, 32'hFFFFFFFF);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'hC0C0C0C0);
    apb(1'b1, 8'h00, 32'h00000080);
    apb(1'b1, 8'h04, 32'h00004000);
    apb(1'b1, 8'h20, 32'h00000021);
    irq <= 32'h00000021;
    offer;
    chk(va, {6'h15, 32'h00000054});
    chk(stk, 6'h15);
    irq <= 32'h00000001;
    offer;
    chk(va, {6'h10, 32'h00000040});
    irq <= 32'h0;
    apb(1'b1, 8'h20, 32'h0);
  endtask : t_prio

  task t_sys;
    svc <= 1'b1;
    @(posedge clk);
    svc <= 1'b0;
    offer;
    chk(va, {6'h0B, 32'h0000002C});
    fault <= 1'b1;
    @(posedge clk);
    fault <= 1'b0;
    offer;
    chk(va, {6'h03, 32'h0000000C});
    apb(1'b1, 8'h44, 32'h1);
    offer;
    chk(va, {6'h0E, 32'h00000038});
    chk(stk, 6'h0E);
  endtask : t_sys

  task t_wake;
    apb(1'b1, 8'h4C, 32'h4);
    apb(1'b1, 8'h20, 32'h2);
    irq <= 32'h2;
    repeat (3) @(posedge clk);
    chk(wake, 1'b0);
    apb(1'b1, 8'h4C, 32'h3);
    repeat (2) @(posedge clk);
    chk(wake, 1'b1);
    irq <= 32'h0;
    apb(1'b1, 8'h20, 32'h0);
  endtask : t_wake

  // An unrouted pin must raise nothing; the status bit is masked first.
  task t_nmi;
    nmi_n <= 1'b0;
    repeat (20) @(posedge clk);
    chk(req, 1'b0);
    nmi_n <= 1'b1;
    apb(1'b1, 8'h3C, 32'h1);
    nmi_n <= 1'b0;
    offer;
    chk(va, {6'h02, 32'h00000008});
    chk(int_o, 1'b0);
    apb(1'b1, 8'h28, 32'h1);
    repeat (2) @(posedge clk);
    chk(int_o, 1'b1);
    apb(1'b1, 8'h24, 32'h1);
    repeat (2) @(posedge clk);
    chk(int_o, 1'b0);
    nmi_n <= 1'b1;
  endtask : t_nmi

  // Reads of the count span a measured gap; the divided rate may land
  // up to one count above the exact ratio because of prescaler phase.
  task t_tick_rate;
    apb(1'b1, 8'h30, 32'h00FFFFFF);
    apb(1'b1, 8'h2C, 32'h5);
    apb(1'b0, 8'h34, 32'h0);
    a = rd;
    c = t_s;
    repeat (32) @(posedge clk);
    apb(1'b0, 8'h34, 32'h0);
    chk(a - rd, t_s - c);
    apb(1'b1, 8'h2C, 32'h1);
    apb(1'b0, 8'h34, 32'h0);
    a = rd;
    c = t_s;
    repeat (64) @(posedge clk);
    apb(1'b0, 8'h34, 32'h0);
    g = (t_s - c) / 16;
    chk((a - rd) >= g && (a - rd) <= g + 1, 1'b1);
    apb(1'b1, 8'h2C, 32'h0);
    apb(1'b0, 8'h38, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h80, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
  endtask : t_tick_rate

  task t_tick_vec;
    apb(1'b1, 8'h30, 32'h14);
    apb(1'b1, 8'h34, 32'h0);
    apb(1'b1, 8'h2C, 32'h7);
    offer;
    chk(va, {6'h0F, 32'h0000003C});
    apb(1'b1, 8'h2C, 32'h0);
  endtask : t_tick_vec

  // Reset, then each scenario in turn; the core model answers slowly,
  // promptly and very slowly across the run.
  initial begin
    {rst_n, psel, penable, pwrite, fault, svc} = 6'h00;
    {paddr, pwdata, irq} = 72'h0;
    nmi_n = 1'b1;
    delay = 4'h3;
    {n_fail, compares, cyc} = 96'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_prio;
    t_sys;
    delay <= 4'h0;
    t_wake;
    t_nmi;
    t_tick_rate;
    delay <= 4'h7;
    t_tick_vec;
    close_out();
  end
endmodule : core_exception_priority_tb

//--- testbench/core_model.sv
`timescale 1ns/1ns
// Behavioural core: it takes each offered vector after a set delay and
// returns from the handler the same delay later. It never acknowledges
// outside an offer, so a stray ack cannot mask a design fault.
module core_model (
  input  wire logic       clk_in,   // Core clock.
  input  wire logic       rstn_in,  // Reset, active low.
  input  wire logic       req_in,   // Vector offered.
  input  wire logic [3:0] delay_in, // Answer delay in cycles.
  output logic            ack_out,  // Vector taken.
  output logic            done_out  // Handler return pulse.
);
  logic [3:0] cnt_reg;
  logic       busy_reg;

  // Wait out the delay, take the vector, then return after it again.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_reg <= 4'h0;
      busy_reg <= 1'b0;
      ack_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      ack_out <= 1'b0;
      done_out <= 1'b0;
      cnt_reg <= 4'h0;
      if (busy_reg) begin
        cnt_reg <= cnt_reg + 4'h1;
        if (cnt_reg >= delay_in) begin
          done_out <= 1'b1;
          busy_reg <= 1'b0;
          cnt_reg <= 4'h0;
        end
      end else if (req_in && !ack_out) begin
        cnt_reg <= cnt_reg + 4'h1;
        if (cnt_reg >= delay_in) begin
          ack_out <= 1'b1;
          busy_reg <= 1'b1;
          cnt_reg <= 4'h0;
        end
      end
    end
  end
endmodule : core_model
